/* File: bench/rssq_card_model.sv */
// Removable program card model: sixteen words, optional protection and a password.
// Assumes the sequencer reads one word a cycle at card_addr while the card is inserted.
`timescale 1ns/10ps
module rssq_card_model #(
   parameter logic [15:0] PW = 16'hC3A5
) (
   input wire logic inserted,
   input wire logic protect,
   input wire logic [3:0] card_addr,
   output logic card_present,
   output logic card_protected,
   output logic [rssq_pkg::PW_W-1:0] card_password,
   output logic [rssq_pkg::WORD_W-1:0] card_word
);
   // ==========================================================
   // Card contents
   // A pulled card leaves a floating bus, so the word is scrambled rather than held.
   assign card_present = inserted;
   assign card_protected = inserted & protect;
   assign card_password = PW;
   assign card_word = inserted ? {card_addr, ~card_addr} : {~card_addr, card_addr};
endmodule

/* File: bench/rssq_sequencer_tb.sv */
// Testbench for the run/stop sequencer: power-on modes, card copy, lamps, password gate, program cycle.
// Assumes the card model and the design sources are compiled before it.
`timescale 1ns/10ps
module rssq_sequencer_tb;
   localparam longint unsigned GATE = 60;
   localparam logic [15:0] PW = 16'hC3A5;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic mem_valid = 1'b0, ins = 1'b0, prot = 1'b0;
   logic card_present, card_protected;
   logic [15:0] card_password;
   logic [7:0] card_word;
   logic [3:0] card_addr;
   logic pc_cable = 1'b1, pc_start = 1'b0, pc_stop = 1'b0, pc_delete = 1'b0, pc_load = 1'b0;
   logic [3:0] pc_load_addr = 4'h0, pc_read_addr = 4'h0;
   logic [7:0] pc_load_word = 8'h00, pc_read_data, plant_in = 8'h00;
   logic pc_pw_valid = 1'b0, pc_read_req = 1'b0, pc_read_ack, pc_read_denied;
   logic [15:0] pc_pw = 16'h0000;
   logic [3:0] plant_out;
   logic lamp_red, lamp_green, run_flag, inv_flag;
   logic [31:0] cycle_periods;
   int errors = 0, tests_run = 0, cycles = 0;
   logic ack, den;
   logic [7:0] dat;

   rssq_card_model #(.PW(PW)) i_rssq_card_model (.inserted(ins), .protect(prot), .card_addr(card_addr),
      .card_present(card_present), .card_protected(card_protected), .card_password(card_password),
      .card_word(card_word));
   rssq_sequencer #(.GATE_CYCLES(GATE)) i_rssq_sequencer (.clk(clk), .reset(reset), .mem_valid(mem_valid),
      .card_present(card_present), .card_protected(card_protected), .card_password(card_password),
      .card_word(card_word), .card_addr(card_addr), .pc_cable(pc_cable), .pc_start(pc_start),
      .pc_stop(pc_stop), .pc_delete(pc_delete), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
      .pc_load_word(pc_load_word), .pc_pw_valid(pc_pw_valid), .pc_pw(pc_pw), .pc_read_req(pc_read_req),
      .pc_read_addr(pc_read_addr), .pc_read_ack(pc_read_ack), .pc_read_denied(pc_read_denied),
      .pc_read_data(pc_read_data), .plant_in(plant_in), .plant_out(plant_out), .lamp_red(lamp_red),
      .lamp_green(lamp_green), .run_flag(run_flag), .inv_flag(inv_flag), .cycle_periods(cycle_periods));

   // ==========================================================
   // Clock, timeout and reporting
   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // ==========================================================
   // Drivers: every input changes 1 ns after a rising edge.
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic boot(input logic mv, input logic in, input logic pr);
      mem_valid = mv;
      ins = in;
      prot = pr;
      reset = 1'b1;
      tick(12);
      reset = 1'b0;
   endtask

   // Bits are start, stop, delete; one-cycle pulse.
   task automatic pc_cmd(input logic [2:0] c);
      {pc_start, pc_stop, pc_delete} = c;
      tick();
      {pc_start, pc_stop, pc_delete} = 3'b000;
      tick(3);
   endtask

   // The answer stands for one cycle only, so it is taken right after the edge that samples the request.
   task automatic pc_read(input logic [3:0] a);
      pc_read_addr = a;
      pc_read_req = 1'b1;
      tick();
      ack = pc_read_ack;
      den = pc_read_denied;
      dat = pc_read_data;
      pc_read_req = 1'b0;
      tick();
   endtask

   task automatic give_pw(input logic [15:0] p);
      pc_pw = p;
      pc_pw_valid = 1'b1;
      tick();
      pc_pw_valid = 1'b0;
      tick(2);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_empty();
      boot(1'b0, 1'b0, 1'b0);
      tick(4);
      check("out empty", plant_out, 0);
      check("run empty", run_flag, 0);
      check("red empty", lamp_red, 1);
      check("green empty", lamp_green, 0);
      pc_load_addr = 4'h0;
      pc_load_word = 8'hFF;
      pc_cable = 1'b0;
      pc_load = 1'b1;
      tick();
      pc_load = 1'b0;
      pc_cmd(3'b100);
      check("run no cable", run_flag, 0);
      pc_cable = 1'b1;
      pc_cmd(3'b100);
      check("run no program", run_flag, 0);
      pc_load = 1'b1;
      tick();
      pc_load = 1'b0;
      pc_cmd(3'b100);
      check("run pc start", run_flag, 1);
      check("green pc start", lamp_green, 1);
      check("red pc start", lamp_red, 0);
      pc_cmd(3'b010);
      check("run pc stop", run_flag, 0);
      check("red pc stop", lamp_red, 1);
      $display("test empty done");
   endtask

   task automatic t_memory();
      boot(1'b1, 1'b0, 1'b0);
      tick(4);
      check("run mem", run_flag, 1);
      check("green mem", lamp_green, 1);
      check("red mem", lamp_red, 0);
      pc_load = 1'b1;
      tick();
      pc_load = 1'b0;
      tick();
      check("run load stops", run_flag, 0);
      $display("test memory done");
   endtask

   task automatic t_card();
      int flips;
      logic last;
      flips = 0;
      boot(1'b1, 1'b1, 1'b0);
      tick(10);
      check("run mid copy", run_flag, 0);
      check("red mid copy", lamp_red, 1);
      tick(10);
      check("run after copy", run_flag, 1);
      pc_read(4'h5);
      check("ack card", ack, 1);
      check("data card", dat, {4'h5, 4'hA});
      tick();
      check("data drops", pc_read_data, 0);
      check("ack drops", pc_read_ack, 0);
      plant_in = 8'h01;
      tick(12);
      check("plant out", plant_out, 4'b0101);
      last = inv_flag;
      repeat (30) begin
         tick();
         if (inv_flag !== last) flips++;
         last = inv_flag;
      end
      check("flag toggles", flips, 10);
      tick(2 * GATE + 10);
      // One flag period is two program cycles of three clocks each.
      check("meter periods", cycle_periods, 32'(GATE / 6));
      plant_in = 8'h00;
      $display("test card done");
   endtask

   task automatic t_protect();
      boot(1'b0, 1'b1, 1'b1);
      tick(20);
      pc_read(4'h0);
      check("denied locked", den, 1);
      check("data locked", dat, 0);
      give_pw(PW ^ 16'h0001);
      pc_read(4'h0);
      check("denied wrong pw", den, 1);
      give_pw(PW);
      pc_read(4'h0);
      check("denied right pw", den, 0);
      check("data right pw", dat, 8'h0F);
      ins = 1'b0;
      tick(3);
      pc_read(4'h0);
      check("kept after unlock", dat, 8'h0F);
      boot(1'b0, 1'b1, 1'b1);
      tick(20);
      ins = 1'b0;
      tick(3);
      pc_read(4'h0);
      check("erased data", dat, rssq_pkg::WORD_ERASED);
      check("erased run", run_flag, 0);
      $display("test protect done");
   endtask

   task automatic t_delete();
      boot(1'b1, 1'b1, 1'b1);
      tick(20);
      pc_cmd(3'b010);
      pc_cmd(3'b001);
      pc_read(4'h5);
      check("denied deleted", den, 0);
      check("data deleted", dat, 0);
      pc_cmd(3'b100);
      check("run deleted", run_flag, 0);
      $display("test delete done");
   endtask

   initial begin
      t_empty();
      t_memory();
      t_card();
      t_protect();
      t_delete();
      give_verdict();
   end
endmodule

/* File: logic/rssq_cycle_meter.sv */
// Cycle meter: counts rising edges of a once-per-cycle inverted flag over a gate window.
// Assumes the flag is a synchronous level driven by the sequencer.
`timescale 1ns/10ps
module rssq_cycle_meter #(
   parameter longint unsigned GATE_CYCLES = rssq_pkg::GATE_CYCLES,
   parameter int unsigned CNT_W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic flag,
   output logic [CNT_W-1:0] periods
);
   logic [63:0] gate_reg;
   logic [CNT_W-1:0] count_reg;
   logic flag_reg;
   logic rise;

   assign rise = flag & ~flag_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag;
      end
   end

   // One rising edge per period, that is per two program cycles.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gate_reg <= 64'h0000_0000_0000_0000;
         count_reg <= '0;
         periods <= '0;
      end else if (gate_reg == GATE_CYCLES - 64'd1) begin
         gate_reg <= 64'h0000_0000_0000_0000;
         periods <= count_reg + CNT_W'(rise);
         count_reg <= '0;
      end else begin
         gate_reg <= gate_reg + 64'd1;
         count_reg <= count_reg + CNT_W'(rise);
      end
   end
endmodule

/* File: logic/rssq_pkg.sv */
// Package: constants and types of the run/stop startup sequencer.
// Assumes a 100 MHz system clock; every other rate is a derived count.
package rssq_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned GATE_TIME_S = 2;
   localparam longint unsigned GATE_CYCLES = longint'(GATE_TIME_S) * 64'h0000_0000_3B9A_CA00 / CLK_PERIOD_NS;
   localparam int unsigned PROG_WORDS = 16;
   localparam int unsigned WORD_W = 8;
   localparam int unsigned PW_W = 16;
   localparam logic [15:0] PW_NONE = 16'h0000;
   localparam logic [7:0] WORD_ERASED = 8'h00;

   typedef enum logic [2:0] {
      RSSQ_ST_POWERUP,
      RSSQ_ST_COPY,
      RSSQ_ST_STOP,
      RSSQ_ST_RUN
   } rssq_mode_e;

   typedef enum logic [1:0] {
      RSSQ_PH_READ,
      RSSQ_PH_EVAL,
      RSSQ_PH_WRITE
   } rssq_phase_e;
endpackage

/* File: logic/rssq_sequencer.sv */
// Top: power-on mode sequencer with card copy, lamps, password gate and program cycle.
// Assumes card and PC link inputs are synchronous to clk; one word per cycle from card.
// Behaviour
// - With no program in memory or on a card the controller stays in STOP after power-on.
// - With a valid program in internal memory it goes to RUN by itself at power-on.
// - A card present at power-on is copied into internal memory at once, overwriting it.
// - After the card copy completes the controller goes from COPY to RUN by itself.
// - Download and start come only from the PC link and only while its cable is attached.
// - The red lamp is lit after power-up and in every state other than RUN.
// - The green lamp is lit whenever the controller is in RUN.
// - A protected card blocks live data read-out until the correct password is given.
// - Removing a protected card without the password erases the internal program.
// - Each program cycle reads inputs, then evaluates the program, then writes outputs.
// - An inverted flag toggles once per program cycle, so a period spans two cycles.
// - A meter counts flag periods over a two-second gate window.
// - A delete request from the PC clears both the program and the password.
`timescale 1ns/10ps
module rssq_sequencer #(
   parameter int unsigned IN_W = 8,
   parameter int unsigned OUT_W = 4,
   parameter longint unsigned GATE_CYCLES = rssq_pkg::GATE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic mem_valid,
   input wire logic card_present,
   input wire logic card_protected,
   input wire logic [rssq_pkg::PW_W-1:0] card_password,
   input wire logic [rssq_pkg::WORD_W-1:0] card_word,
   output logic [3:0] card_addr,
   input wire logic pc_cable,
   input wire logic pc_start,
   input wire logic pc_stop,
   input wire logic pc_delete,
   input wire logic pc_load,
   input wire logic [3:0] pc_load_addr,
   input wire logic [rssq_pkg::WORD_W-1:0] pc_load_word,
   input wire logic pc_pw_valid,
   input wire logic [rssq_pkg::PW_W-1:0] pc_pw,
   input wire logic pc_read_req,
   input wire logic [3:0] pc_read_addr,
   output logic pc_read_ack,
   output logic pc_read_denied,
   output logic [rssq_pkg::WORD_W-1:0] pc_read_data,
   input wire logic [IN_W-1:0] plant_in,
   output logic [OUT_W-1:0] plant_out,
   output logic lamp_red,
   output logic lamp_green,
   output logic run_flag,
   output logic inv_flag,
   output logic [31:0] cycle_periods
);
   rssq_pkg::rssq_mode_e mode_reg;
   rssq_pkg::rssq_phase_e phase_reg;
   logic [rssq_pkg::WORD_W-1:0] prog_reg [rssq_pkg::PROG_WORDS];
   logic prog_valid_reg;
   logic [rssq_pkg::PW_W-1:0] pw_reg;
   logic unlocked_reg;
   logic card_prev_reg;
   logic prot_card_reg;
   logic [3:0] copy_idx_reg;
   logic [IN_W-1:0] in_img_reg;
   logic [OUT_W-1:0] res_reg;
   logic copy_last;
   logic erase;
   logic pc_ok;
   logic [31:0] meter_periods;

   assign copy_last = (copy_idx_reg == 4'(rssq_pkg::PROG_WORDS - 1));
   assign pc_ok = pc_cable;
   // Removal of a locked protected card, or a PC delete, wipes the program.
   assign erase = (card_prev_reg & ~card_present & prot_card_reg & ~unlocked_reg)
      | (pc_ok & pc_delete);

   // ==========================================================
   // Operating mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_reg <= rssq_pkg::RSSQ_ST_POWERUP;
      end else begin
         case (mode_reg)
            rssq_pkg::RSSQ_ST_POWERUP: begin
               if (card_present) begin
                  mode_reg <= rssq_pkg::RSSQ_ST_COPY;
               end else if (mem_valid) begin
                  mode_reg <= rssq_pkg::RSSQ_ST_RUN;
               end else begin
                  mode_reg <= rssq_pkg::RSSQ_ST_STOP;
               end
            end
            rssq_pkg::RSSQ_ST_COPY: begin
               if (copy_last) begin
                  mode_reg <= rssq_pkg::RSSQ_ST_RUN;
               end
            end
            rssq_pkg::RSSQ_ST_STOP: begin
               if (pc_ok && pc_start && prog_valid_reg && !erase) begin
                  mode_reg <= rssq_pkg::RSSQ_ST_RUN;
               end
            end
            rssq_pkg::RSSQ_ST_RUN: begin
               if (erase || (pc_ok && (pc_stop || pc_load))) begin
                  mode_reg <= rssq_pkg::RSSQ_ST_STOP;
               end
            end
            default: mode_reg <= rssq_pkg::RSSQ_ST_STOP;
         endcase
      end
   end

   // ==========================================================
   // Card copy address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         copy_idx_reg <= 4'h0;
      end else if (mode_reg == rssq_pkg::RSSQ_ST_COPY) begin
         copy_idx_reg <= copy_idx_reg + 4'h1;
      end else begin
         copy_idx_reg <= 4'h0;
      end
   end

   assign card_addr = copy_idx_reg;

   // ==========================================================
   // Program store: erase has priority over copy and download.
   generate
      for (genvar i = 0; i < rssq_pkg::PROG_WORDS; i++) begin : g_word
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               prog_reg[i] <= rssq_pkg::WORD_ERASED;
            end else if (erase) begin
               prog_reg[i] <= rssq_pkg::WORD_ERASED;
            end else if (mode_reg == rssq_pkg::RSSQ_ST_COPY && copy_idx_reg == 4'(i)) begin
               prog_reg[i] <= card_word;
            end else if (pc_ok && pc_load && pc_load_addr == 4'(i)) begin
               prog_reg[i] <= pc_load_word;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prog_valid_reg <= 1'b0;
      end else if (erase) begin
         prog_valid_reg <= 1'b0;
      end else if (mode_reg == rssq_pkg::RSSQ_ST_POWERUP) begin
         prog_valid_reg <= mem_valid | card_present;
      end else if (pc_ok && pc_load) begin
         prog_valid_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Password and protection state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pw_reg <= rssq_pkg::PW_NONE;
         prot_card_reg <= 1'b0;
         unlocked_reg <= 1'b0;
         card_prev_reg <= 1'b0;
      end else begin
         card_prev_reg <= card_present;
         if (erase) begin
            pw_reg <= rssq_pkg::PW_NONE;
            prot_card_reg <= 1'b0;
            unlocked_reg <= 1'b0;
         end else begin
            if (card_present && !card_prev_reg) begin
               prot_card_reg <= card_protected;
               pw_reg <= card_password;
               unlocked_reg <= 1'b0;
            end else if (!card_present) begin
               prot_card_reg <= 1'b0;
            end
            if (pc_ok && pc_pw_valid && pc_pw == pw_reg) begin
               unlocked_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Online read-out, answered one cycle after the request.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pc_read_ack <= 1'b0;
         pc_read_denied <= 1'b0;
         pc_read_data <= rssq_pkg::WORD_ERASED;
      end else begin
         pc_read_ack <= pc_ok & pc_read_req;
         pc_read_denied <= pc_ok & pc_read_req & prot_card_reg & ~unlocked_reg;
         if (pc_ok && pc_read_req && !(prot_card_reg && !unlocked_reg)) begin
            pc_read_data <= prog_reg[pc_read_addr];
         end else begin
            pc_read_data <= rssq_pkg::WORD_ERASED;
         end
      end
   end

   // ==========================================================
   // Program cycle: read inputs, evaluate, write outputs.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_reg <= rssq_pkg::RSSQ_PH_READ;
         in_img_reg <= '0;
         res_reg <= '0;
         plant_out <= '0;
         inv_flag <= 1'b0;
      end else if (mode_reg != rssq_pkg::RSSQ_ST_RUN) begin
         phase_reg <= rssq_pkg::RSSQ_PH_READ;
         plant_out <= '0;
      end else begin
         case (phase_reg)
            rssq_pkg::RSSQ_PH_READ: begin
               in_img_reg <= plant_in;
               phase_reg <= rssq_pkg::RSSQ_PH_EVAL;
            end
            rssq_pkg::RSSQ_PH_EVAL: begin
               // The stored program is a mask per output over the input image.
               for (int k = 0; k < OUT_W; k++) begin
                  res_reg[k] <= |(in_img_reg & IN_W'(prog_reg[k]));
               end
               phase_reg <= rssq_pkg::RSSQ_PH_WRITE;
            end
            rssq_pkg::RSSQ_PH_WRITE: begin
               plant_out <= res_reg;
               inv_flag <= ~inv_flag;
               phase_reg <= rssq_pkg::RSSQ_PH_READ;
            end
            default: phase_reg <= rssq_pkg::RSSQ_PH_READ;
         endcase
      end
   end

   // ==========================================================
   // Lamps
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lamp_red <= 1'b1;
         lamp_green <= 1'b0;
         run_flag <= 1'b0;
      end else begin
         lamp_red <= (mode_reg != rssq_pkg::RSSQ_ST_RUN);
         lamp_green <= (mode_reg == rssq_pkg::RSSQ_ST_RUN);
         run_flag <= (mode_reg == rssq_pkg::RSSQ_ST_RUN);
      end
   end

   rssq_cycle_meter #(
      .GATE_CYCLES(GATE_CYCLES),
      .CNT_W(32)
   ) u_meter (
      .clk(clk),
      .reset(reset),
      .flag(inv_flag),
      .periods(meter_periods)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cycle_periods <= 32'h0000_0000;
      end else begin
         cycle_periods <= meter_periods;
      end
   end

   // ==========================================================
   // Assertions
   sequence s_copy_done;
      mode_reg == rssq_pkg::RSSQ_ST_COPY && copy_last;
   endsequence

   property p_empty_stop;
      @(posedge clk) disable iff (reset)
      mode_reg == rssq_pkg::RSSQ_ST_POWERUP && !card_present && !mem_valid |=> mode_reg == rssq_pkg::RSSQ_ST_STOP;
   endproperty
   a_empty_stop: assert property (p_empty_stop) else $error("empty start not in stop");

   property p_mem_run;
      @(posedge clk) disable iff (reset)
      mode_reg == rssq_pkg::RSSQ_ST_POWERUP && !card_present && mem_valid |=> mode_reg == rssq_pkg::RSSQ_ST_RUN;
   endproperty
   a_mem_run: assert property (p_mem_run) else $error("valid memory did not start");

   property p_card_first;
      @(posedge clk) disable iff (reset)
      mode_reg == rssq_pkg::RSSQ_ST_POWERUP && card_present |=> mode_reg == rssq_pkg::RSSQ_ST_COPY;
   endproperty
   a_card_first: assert property (p_card_first) else $error("card not copied first");

   property p_copy_run;
      @(posedge clk) disable iff (reset)
      s_copy_done |=> mode_reg == rssq_pkg::RSSQ_ST_RUN ##1 lamp_green;
   endproperty
   a_copy_run: assert property (p_copy_run) else $error("no run after copy");

   property p_lamps;
      @(posedge clk) disable iff (reset)
      1'b1 |=> lamp_green == ($past(mode_reg) == rssq_pkg::RSSQ_ST_RUN) && lamp_red != lamp_green;
   endproperty
   a_lamps: assert property (p_lamps) else $error("lamp state wrong");

   property p_read_lock;
      @(posedge clk) disable iff (reset)
      pc_cable && pc_read_req && prot_card_reg && !unlocked_reg |=>
         pc_read_denied && pc_read_data == rssq_pkg::WORD_ERASED;
   endproperty
   a_read_lock: assert property (p_read_lock) else $error("locked read not denied");

   property p_erase;
      @(posedge clk) disable iff (reset)
      erase |=> !prog_valid_reg && pw_reg == rssq_pkg::PW_NONE && prog_reg[0] == rssq_pkg::WORD_ERASED;
   endproperty
   a_erase: assert property (p_erase) else $error("program not erased");

   property p_no_cable;
      @(posedge clk) disable iff (reset)
      !pc_cable && mode_reg == rssq_pkg::RSSQ_ST_STOP |=> mode_reg == rssq_pkg::RSSQ_ST_STOP;
   endproperty
   a_no_cable: assert property (p_no_cable) else $error("started without cable");

   property p_toggle;
      @(posedge clk) disable iff (reset)
      mode_reg == rssq_pkg::RSSQ_ST_RUN && phase_reg == rssq_pkg::RSSQ_PH_WRITE |=> inv_flag != $past(inv_flag);
   endproperty
   a_toggle: assert property (p_toggle) else $error("flag did not toggle");
endmodule
